// ===== include/sie_defs.svh
// Purpose: constants of the setup insert / self-test / EOI hold-off core
// Assumes: 40 MHz sys_clk
// Notes:   offsets are byte addresses on the Avalon slave
`ifndef SIE_DEFS_SVH
`define SIE_DEFS_SVH
// ****************************************
// slot range and modes
// ****************************************
`define SIE_MIN_SLOT     7'h01
`define SIE_MAX_SLOT     7'h64
`define SIE_DEFAULT_EOI_HOLDOFF_MODE 3'h0
`define SIE_MODE_MAX     3'h5
`define SIE_MODE_NOEOI   0
`define SIE_MODE_NOHOLD  3'h2
`define SIE_MODE_MATRIX  3'h4
`define SIE_TEST_PARAM   7'h00
// ****************************************
// timing
// ****************************************
`define SIE_CLK_KHZ      40000
`define SIE_TEST_MS      4000
`define SIE_TEST_CYC     (`SIE_TEST_MS * `SIE_CLK_KHZ)
// ****************************************
// register map
// ****************************************
`define SIE_REG_MODE     5'h00
`define SIE_REG_FAULT    5'h04
`define SIE_REG_IRQ_ST   5'h08
`define SIE_REG_IRQ_MASK 5'h0C
`define SIE_REG_SEL      5'h10
`define SIE_REG_DATA     5'h14
`define SIE_BAD_READ     32'hDEAD_BEEF
// ****************************************
// field positions
// ****************************************
`define SIE_FAULT_SELFTEST 0
`define SIE_IRQ_INS_DONE   0
`define SIE_IRQ_TEST_DONE  1
`define SIE_IRQ_TEST_FAIL  2
`define SIE_IRQ_REJECT     3
`define SIE_SEL_WORD_LSB   8
`endif

// ===== include/sie_pkg.sv
// Purpose: shared types of the setup insert / self-test / EOI hold-off core
// Assumes: included before rtl files
// Notes:   states are one-hot
package sie_pkg;
  typedef enum logic [1:0] {
    SIE_OP_INSERT   = 2'h0,
    SIE_OP_SELFTEST = 2'h1,
    SIE_OP_EOIHOLD  = 2'h2,
    SIE_OP_DEFAULTS = 2'h3
  } sie_op_t;
  typedef enum logic [3:0] {
    SIE_ST_IDLE  = 4'h1,
    SIE_ST_SHIFT = 4'h2,
    SIE_ST_CLEAR = 4'h4,
    SIE_ST_TEST  = 4'h8
  } sie_state_t;
endpackage

// ===== rtl/sie_cmd_core.sv
// Purpose: insert-blank-setup, self-test and EOI/hold-off handlers
// Assumes: command parser on sys_clk; key and relay-settle inputs are pins
// Notes:   setups are flip-flops; software sees them through SEL/DATA
//          registers: 0x00 mode (bits 2:0); 0x04 fault word, bit 0 self-test
//          failed, a write on byte lane 0 clears it unless a failure lands then; 0x08 interrupt status, a read clears
//          it and an event in the same cycle wins; 0x0C interrupt mask
//          0x10 setup select, slot in bits 6:0, word in bits 9:8
//          0x14 data word of the selected setup, writable only when idle
//          interrupt bits: 0 insert done, 1 test done, 2 test failed,
//          3 command refused
//          insert at n costs 100-n shift cycles and one clear cycle
//          self-test runs TESTCYC cycles with NRFD held all the while
//          each register access takes two cycles: one wait, one answer
//          clock enable low freezes every flop, synchronisers too
//          limitation: commands arriving while busy are dropped, and only
//          the self-test covers that with NRFD; callers wait for idle
//
// Functional notes
// - insert location is 1 to 100; controller sends nothing else
// - insert at n moves setups 99..n up one slot, top first
// - after the shift, setup n is cleared to no crosspoints
// - front panel display is blanked during an insert
// - self-test fault lights lamp and sets fault word bit
// - lamp goes off on next keypress or next bus command
// - NRFD held asserted for the whole self-test
// - mode 0..5; even modes send EOI, odd modes suppress it
// - modes 0,1 hold until Ready; 2,3 no hold; 4,5 until Matrix Ready
// - power-up, DCL/SDC and defaults restore set mode 0
// - with EOI enabled, EOI goes with last talked byte
// - hold-off asserts NRFD on execute char until commands done
// - buffer sends carry EOI only on final byte of whole transfer
// - terminator: EOI on its last byte
// - NRFD is shared, so hold-off stalls all bus traffic
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "sie_defs.svh"
module sie_cmd_core #(
  parameter int SLOTS   = 100,               // stored setups
  parameter int XW      = 96,                // crosspoints per setup
  parameter int TESTCYC = `SIE_TEST_CYC      // self-test duration in cycles
) (
  // clocking
  input  wire logic        sys_clk,            // 40 MHz clock
  input  wire logic        rst_n,              // async reset, low
  input  wire logic        clkEn,              // freezes all state when low
  // parsed commands from the bus front end, then the ROM/RAM checker fault
  input  wire logic        cmdValid,           // command pulse from parser
  input  wire logic [1:0]  cmdOp,              // sie_pkg::sie_op_t
  input  wire logic [6:0]  cmdParam,           // command parameter
  input  wire logic        execChar,           // execute char received
  input  wire logic        devClear,           // DCL or SDC
  input  wire logic        memFault,           // ROM/RAM checker fault level
  // front panel and relay pins
  input  wire logic        keyPressPin,        // front panel key, async
  input  wire logic        relaySettledPin,    // relays settled, async
  // talker path
  input  wire logic        talkValid,          // byte to talk
  input  wire logic [7:0]  talkByte,           // talked byte
  input  wire logic        talkLast,           // last byte of whole transfer
  // bus lines
  output logic             busDataValid,       // byte on bus
  output logic [7:0]       busData,            // byte to bus
  output logic             busEoi,             // EOI with byte
  output logic             nrfdOut,            // NRFD level driven (low)
  output logic             nrfdOe,             // NRFD driven
  // panel indicators and interrupt
  output logic             faultLamp,          // fault lamp
  output logic             displayBlank,       // panel display blanked
  output logic             irq,                // level interrupt
  // register slave
  input  wire logic [4:0]  avs_address,        // byte address
  input  wire logic        avs_read,           // read strobe
  input  wire logic        avs_write,          // write strobe
  input  wire logic [31:0] avs_writedata,      // write data
  input  wire logic [3:0]  avs_byteenable,     // byte lanes
  output logic [31:0]      avs_readdata,       // read data
  output logic             avs_waitrequest     // stall
);
  // words per setup and width of the self-test counter
  localparam int NW = XW / 32;
  localparam int CW = $clog2(TESTCYC + 1);

  // ****************************************
  // elaboration checks
  // ****************************************
  // the top slot is fixed at 100, so a smaller store cannot take the shift
  if (SLOTS < `SIE_MAX_SLOT || SLOTS > 127)
  begin : g_bad_slots
    $error("sie_cmd_core: SLOTS must lie in 100..127");
  end
  // the word select is two bits and refuses its top code: 1 to 3 words
  if (XW % 32 != 0 || NW < 1 || NW > 3)
  begin : g_bad_width
    $error("sie_cmd_core: XW must be 32, 64 or 96");
  end
  if (TESTCYC < 1)
  begin : g_bad_test
    $error("sie_cmd_core: TESTCYC must be at least 1");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    // setup store
    logic [SLOTS-1:0][XW-1:0] mem;
    // command sequencer
    sie_pkg::sie_state_t      state;
    logic [6:0]               ptr;
    logic [6:0]               target;
    // self-test
    logic [CW-1:0]            testCnt;
    logic                     testBad;
    // eoi and hold-off
    logic [2:0]               mode;
    logic                     hold;
    logic                     nrfd;
    // talker
    logic                     dv;
    logic [7:0]               data;
    logic                     eoi;
    // panel
    logic                     lamp;
    logic                     blank;
    // status and interrupts
    logic                     faultSelf;
    logic [3:0]               irqSt;
    logic [3:0]               irqMask;
    logic                     irqQ;
    // register slave
    logic [6:0]               selSlot;
    logic [1:0]               selWord;
    logic                     waitQ;
    logic [31:0]              rdata;
    // pin synchronisers
    logic [2:0]               keySync;
    logic                     keyStable;
    logic [2:0]               mrSync;
    logic                     mrStable;
  } sie_core_st_t;

  sie_core_st_t s_reg;
  sie_core_st_t s_next;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    // per-cycle helpers
    logic [3:0]  ev;
    logic        keyEdge;
    logic        mtxReady;
    logic        acc;
    logic [6:0]  rdIdx;
    s_next   = s_reg;
    ev       = 4'h0;
    keyEdge  = 1'b0;
    mtxReady = 1'b0;
    acc      = avs_read || avs_write;
    rdIdx    = s_reg.selSlot - `SIE_MIN_SLOT;

    // ****************************************
    // pin synchronisers
    // ****************************************
    // pin inputs: a change counts once stages two and three agree
    s_next.keySync = {s_reg.keySync[1:0], keyPressPin};
    s_next.mrSync  = {s_reg.mrSync[1:0], relaySettledPin};
    if (s_reg.keySync[1] == s_reg.keySync[2])
    begin
      s_next.keyStable = s_reg.keySync[2];
      keyEdge = s_reg.keySync[2] && !s_reg.keyStable;
    end
    if (s_reg.mrSync[1] == s_reg.mrSync[2])
      s_next.mrStable = s_reg.mrSync[2];
    mtxReady = s_reg.mrStable;

    // lamp off on key or command; a new fault below wins
    if (keyEdge || cmdValid)
      s_next.lamp = 1'b0;

    // ****************************************
    // command handlers
    // ****************************************
    case (s_reg.state)
      sie_pkg::SIE_ST_IDLE:
      begin
        if (cmdValid)
        begin
          case (sie_pkg::sie_op_t'(cmdOp))
            sie_pkg::SIE_OP_INSERT:
              if (cmdParam < `SIE_MIN_SLOT || cmdParam > `SIE_MAX_SLOT)
                ev[`SIE_IRQ_REJECT] = 1'b1;
              else
              begin
                s_next.target = cmdParam;
                s_next.ptr    = `SIE_MAX_SLOT;
                s_next.blank  = 1'b1;
                s_next.state  = (cmdParam == `SIE_MAX_SLOT) ?
                  sie_pkg::SIE_ST_CLEAR : sie_pkg::SIE_ST_SHIFT;
              end
            sie_pkg::SIE_OP_SELFTEST:
              if (cmdParam != `SIE_TEST_PARAM)
                ev[`SIE_IRQ_REJECT] = 1'b1;
              else
              begin
                s_next.testCnt = CW'(TESTCYC - 1);
                s_next.testBad = 1'b0;
                s_next.state   = sie_pkg::SIE_ST_TEST;
              end
            // modes above 5 are refused like a bad insert
            sie_pkg::SIE_OP_EOIHOLD:
              if (cmdParam > 7'(`SIE_MODE_MAX))
                ev[`SIE_IRQ_REJECT] = 1'b1;
              else
                s_next.mode = cmdParam[2:0];
            // remaining code restores the power-up mode
            default:
              s_next.mode = `SIE_DEFAULT_EOI_HOLDOFF_MODE;
          endcase
        end
      end
      sie_pkg::SIE_ST_SHIFT:
      begin
        // one slot per cycle, highest destination first
        // top-down, so no setup is overwritten before it has moved
        s_next.mem[s_reg.ptr - `SIE_MIN_SLOT] =
          s_reg.mem[s_reg.ptr - 7'h02];
        s_next.ptr = s_reg.ptr - `SIE_MIN_SLOT;
        if (s_reg.ptr == s_reg.target + `SIE_MIN_SLOT)
          s_next.state = sie_pkg::SIE_ST_CLEAR;
      end
      sie_pkg::SIE_ST_CLEAR:
      begin
        // done raised with the clear: software never sees half a setup
        s_next.mem[s_reg.target - `SIE_MIN_SLOT] = '0;
        s_next.blank = 1'b0;
        s_next.state = sie_pkg::SIE_ST_IDLE;
        ev[`SIE_IRQ_INS_DONE] = 1'b1;
      end
      sie_pkg::SIE_ST_TEST:
      begin
        // a fault at any cycle of the window fails the test
        s_next.testBad = s_reg.testBad || memFault;
        s_next.testCnt = s_reg.testCnt - CW'(1);
        if (s_reg.testCnt == '0)
        begin
          s_next.state = sie_pkg::SIE_ST_IDLE;
          ev[`SIE_IRQ_TEST_DONE] = 1'b1;
          if (s_next.testBad)
          begin
            s_next.lamp = 1'b1;
            s_next.faultSelf = 1'b1;
            ev[`SIE_IRQ_TEST_FAIL] = 1'b1;
          end
        end
      end
      default:
        s_next.state = sie_pkg::SIE_ST_IDLE;
    endcase
    // device clear overrides a mode command in the same cycle
    if (devClear)
      s_next.mode = `SIE_DEFAULT_EOI_HOLDOFF_MODE;

    // ****************************************
    // hold-off, NRFD and talker
    // ****************************************
    // hold-off: set on execute char, freed once Ready (or Matrix Ready)
    // a command in this cycle means processing is not yet done
    if (execChar && (s_reg.mode & `SIE_MODE_NOHOLD) == 3'h0)
      s_next.hold = 1'b1;
    else if (s_reg.hold && s_reg.state == sie_pkg::SIE_ST_IDLE && !cmdValid
             && (s_reg.mode < `SIE_MODE_MATRIX || mtxReady))
      s_next.hold = 1'b0;
    // shared line: every talker on the bus stalls meanwhile
    s_next.nrfd = s_next.hold ||
                  s_next.state == sie_pkg::SIE_ST_TEST;

    // talker: EOI only with the last byte of the whole transfer
    // busData keeps the last byte so the lines do not flicker
    s_next.dv   = talkValid;
    s_next.data = talkValid ? talkByte : s_reg.data;
    s_next.eoi  = talkValid && talkLast &&
                  !s_reg.mode[`SIE_MODE_NOEOI];

    // ****************************************
    // register slave
    // ****************************************
    // Avalon slave: one wait cycle, then answer
    // read data comes from a flop, which is what the wait cycle buys
    s_next.waitQ = !(acc && s_reg.waitQ);
    if (acc && s_reg.waitQ)
    begin
      case (avs_address)
        `SIE_REG_MODE:     s_next.rdata = {29'h0, s_reg.mode};
        `SIE_REG_FAULT:
          s_next.rdata = 32'(s_reg.faultSelf) << `SIE_FAULT_SELFTEST;
        `SIE_REG_IRQ_ST:   s_next.rdata = {28'h0, s_reg.irqSt};
        `SIE_REG_IRQ_MASK: s_next.rdata = {28'h0, s_reg.irqMask};
        `SIE_REG_SEL:
          s_next.rdata = {22'h0, s_reg.selWord, 1'b0, s_reg.selSlot};
        `SIE_REG_DATA:     s_next.rdata = s_reg.mem[rdIdx][s_reg.selWord*32 +: 32];
        default:           s_next.rdata = `SIE_BAD_READ;
      endcase
    end
    if (acc && !s_reg.waitQ && avs_read && avs_address == `SIE_REG_IRQ_ST)
      s_next.irqSt = 4'h0;
    if (acc && !s_reg.waitQ && avs_write && avs_byteenable[0])
    begin
      case (avs_address)
        `SIE_REG_MODE:
          if (avs_writedata[2:0] <= `SIE_MODE_MAX)
            s_next.mode = avs_writedata[2:0];
        `SIE_REG_FAULT:    s_next.faultSelf = ev[`SIE_IRQ_TEST_FAIL]; // new failure wins
        `SIE_REG_IRQ_MASK: s_next.irqMask = avs_writedata[3:0];
        `SIE_REG_SEL:
        begin
          if (avs_writedata[6:0] >= `SIE_MIN_SLOT &&
              avs_writedata[6:0] <= 7'(SLOTS))
            s_next.selSlot = avs_writedata[6:0];
          if (avs_writedata[`SIE_SEL_WORD_LSB +: 2] < 2'(NW))
            s_next.selWord = avs_writedata[`SIE_SEL_WORD_LSB +: 2];
        end
        `SIE_REG_DATA:
          if (s_reg.state == sie_pkg::SIE_ST_IDLE)
            s_next.mem[rdIdx][s_reg.selWord*32 +: 32] = avs_writedata;
        default: ;
      endcase
    end
    // ****************************************
    // interrupts
    // ****************************************
    // events set over a clearing read
    s_next.irqSt = s_next.irqSt | ev;
    s_next.irqQ  = |(s_next.irqSt & s_next.irqMask);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // all clear except the fields with a non-zero rest value
      s_reg         <= '0;
      s_reg.state   <= sie_pkg::SIE_ST_IDLE;
      s_reg.mode    <= `SIE_DEFAULT_EOI_HOLDOFF_MODE;
      s_reg.selSlot <= `SIE_MIN_SLOT;
      s_reg.waitQ   <= 1'b1;
    end
    // clkEn low freezes every flop, pin synchronisers included
    else if (clkEn)
      s_reg <= s_next;
  end

  // outputs straight from flops
  assign busDataValid    = s_reg.dv;
  assign busData         = s_reg.data;
  assign busEoi          = s_reg.eoi;
  // open-drain NRFD: the level is always low, only the enable moves
  assign nrfdOut         = 1'b0;
  assign nrfdOe          = s_reg.nrfd;
  // panel and interrupt
  assign faultLamp       = s_reg.lamp;
  assign displayBlank    = s_reg.blank;
  assign irq             = s_reg.irqQ;
  // register slave
  assign avs_readdata    = s_reg.rdata;
  assign avs_waitrequest = s_reg.waitQ;
endmodule

// ===== testbench/sie_cmd_props.sv
// Purpose: port-level properties of the command core
// Assumes: one sys_clk domain, rst_n async active low
// Notes:   bound to every sie_cmd_core instance
`timescale 1ns/1ps
module sie_cmd_props #(
  parameter int TESTCYC = 20 // self-test length in cycles
) (
  input wire logic       sys_clk,         // clock
  input wire logic       rst_n,           // reset, low
  input wire logic       cmdValid,        // command pulse
  input wire logic [1:0] cmdOp,           // opcode
  input wire logic [6:0] cmdParam,        // parameter
  input wire logic       talkValid,       // byte to talk
  input wire logic [7:0] talkByte,        // talked byte
  input wire logic       talkLast,        // last of transfer
  input wire logic       busDataValid,    // byte on bus
  input wire logic [7:0] busData,         // bus byte
  input wire logic       busEoi,          // eoi
  input wire logic       nrfdOut,         // nrfd level
  input wire logic       nrfdOe,          // nrfd driven
  input wire logic       faultLamp,       // lamp
  input wire logic       displayBlank,    // panel blank
  input wire logic       avs_read,        // read
  input wire logic       avs_write,       // write
  input wire logic       avs_waitrequest  // stall
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // idle core taking a legal insert or a self-test
  sequence ins_go;
    cmdValid && cmdOp == 2'h0 && cmdParam inside {[7'h01:7'h64]} && !displayBlank && !nrfdOe;
  endsequence
  sequence test_go;
    TESTCYC > 8 && cmdValid && cmdOp == 2'h1 && cmdParam == 7'h00 && !displayBlank && !nrfdOe;
  endsequence
  talk_follow_a: assert property (talkValid |=> busDataValid && busData == $past(talkByte))
    else $error("talked byte not passed on");
  eoi_last_a: assert property (busEoi |-> busDataValid && $past(talkLast))
    else $error("eoi on a byte that is not last");
  no_stray_a: assert property (!talkValid |=> !busDataValid && !busEoi)
    else $error("bus byte without talk request");
  ack_once_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("avalon answer timing");
  nrfd_low_a: assert property (nrfdOe |-> !nrfdOut)
    else $error("nrfd driven high");
  lamp_off_a: assert property (faultLamp && cmdValid && cmdOp != 2'h1 |=> !faultLamp)
    else $error("lamp stays on after command");
  ins_blank_a: assert property (ins_go |-> ##[1:2] displayBlank)
    else $error("panel not blanked on insert");
  bad_ins_a: assert property (cmdValid && cmdOp == 2'h0 && !displayBlank
    && !(cmdParam inside {[7'h01:7'h64]}) |=> !displayBlank [*2])
    else $error("bad insert ran");
  test_hold_a: assert property (test_go |-> ##[1:2] nrfdOe [*8])
    else $error("nrfd not held in self-test");
endmodule
bind sie_cmd_core sie_cmd_props #(.TESTCYC(TESTCYC)) sie_cmd_props_i (.sys_clk, .rst_n,
  .cmdValid, .cmdOp, .cmdParam, .talkValid, .talkByte, .talkLast, .busDataValid, .busData,
  .busEoi, .nrfdOut, .nrfdOe, .faultLamp, .displayBlank, .avs_read, .avs_write,
  .avs_waitrequest);

// ===== testbench/sie_ctl_model.sv
// Purpose: bus controller stand-in sending parsed commands
// Assumes: shares sys_clk with the core
// Notes:   waits out nrfd hold-off before each send command, not before exe or clr
`timescale 1ns/1ps
module sie_ctl_model (
  input  wire logic       sys_clk,  // clock
  input  wire logic       nrfdOe,   // device holds off
  output logic            cmdValid, // command pulse
  output logic [1:0]      cmdOp,    // opcode
  output logic [6:0]      cmdParam, // parameter
  output logic            execChar, // execute char
  output logic            devClear  // DCL or SDC
);
  initial
  begin
    cmdValid = 1'b0;
    cmdOp = 2'h0;
    cmdParam = 7'h00;
    execChar = 1'b0;
    devClear = 1'b0;
  end
  // ****
  // command tasks
  // ****
  // shared nrfd stalls us like any other talker; bounded so a stuck line ends
  task automatic send(input logic [1:0] op, input logic [6:0] prm);
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (nrfdOe !== 1'b0 && n < 2000);
    if (n >= 2000) tb_top.bad("command hang");
    cmdOp <= op;
    cmdParam <= prm;
    cmdValid <= 1'b1;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
  endtask
  task automatic exe();
    execChar <= 1'b1;
    @(posedge sys_clk);
    execChar <= 1'b0;
  endtask
  task automatic clr();
    devClear <= 1'b1;
    @(posedge sys_clk);
    devClear <= 1'b0;
  endtask
endmodule

// ===== testbench/tb_top.sv
// Purpose: self-checking bench of the command core
// Assumes: self-test shortened to 20 cycles
// Notes:   read data and talked bytes checked from note queues
`timescale 1ns/1ps
`include "sie_defs.svh"
module tb_top;
  logic        sys_clk = 1'b0, rst_n = 1'b0, memFault = 1'b0, keyPressPin = 1'b0;
  logic        relaySettledPin = 1'b1, talkValid = 1'b0, talkLast = 1'b0;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]  talkByte = 8'h00;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, pa, pb;
  wire logic   cmdValid, execChar, devClear, busDataValid, busEoi, nrfdOut, nrfdOe;
  wire logic   faultLamp, displayBlank, irq, avs_waitrequest;
  wire logic [1:0] cmdOp;
  wire logic [6:0] cmdParam;
  wire logic [7:0] busData;
  wire logic [31:0] avs_readdata;
  int          failures = 0, cmp_count = 0, seed = 32'h17b3_2b5e;
  logic [31:0] rdq[$], btq[$];
  always #12.5 sys_clk = ~sys_clk;
  sie_cmd_core #(.TESTCYC(20)) sie_cmd_core_i (.sys_clk, .rst_n, .clkEn(1'b1), .cmdValid,
    .cmdOp, .cmdParam, .execChar, .devClear, .memFault, .keyPressPin, .relaySettledPin,
    .talkValid, .talkByte, .talkLast, .busDataValid, .busData, .busEoi, .nrfdOut, .nrfdOe,
    .faultLamp, .displayBlank, .irq, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest);
  sie_ctl_model sie_ctl_model_i (.sys_clk, .nrfdOe, .cmdValid, .cmdOp, .cmdParam,
    .execChar, .devClear);
  // ****
  // checking tasks
  // ****
  task automatic bad(input string m);
    failures++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) bad(m);
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp) bad(m);
  endtask
  // results arrive one cycle after the request, so they are matched in order
  always @(posedge sys_clk)
  begin
    if (avs_read && avs_waitrequest === 1'b0)
      chk_val(avs_readdata, rdq.size() ? rdq.pop_front() : 32'hx, "read data");
    if (busDataValid === 1'b1)
      chk_val({23'h0, busEoi, busData}, btq.size() ? btq.pop_front() : 32'hx, "talk");
  end
  // ****
  // drivers
  // ****
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) bad("bus hang");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    rdq.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic talk(input logic last, input logic eoi);
    logic [7:0] b;
    b = 8'($random(seed));
    btq.push_back({23'h0, eoi, b});
    talkByte <= b;
    talkLast <= last;
    talkValid <= 1'b1;
    @(posedge sys_clk);
    talkValid <= 1'b0;
    @(posedge sys_clk);
  endtask
  // sync stages need a few cycles before busy flags mean anything
  task automatic settle();
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while ((displayBlank !== 1'b0 || nrfdOe !== 1'b0 || n < 4) && n < 400);
    if (n >= 400) bad("busy hang");
  endtask
  task automatic final_report();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(`SIE_REG_MODE, 32'h0000_0000);
    rd(5'h1C, `SIE_BAD_READ);
    for (int m = 0; m < 6; m++)
    begin
      sie_ctl_model_i.send(2'h2, 7'(m));
      talk(1'b0, 1'b0);
      talk(1'b1, ~m[0]);
    end
    $display("eoi modes done");
    for (int m = 0; m < 6; m += 2)
    begin
      relaySettledPin <= 1'b0;
      repeat (4) @(posedge sys_clk); // settle sync must see the drop first
      sie_ctl_model_i.send(2'h2, 7'(m));
      sie_ctl_model_i.exe();
      @(posedge sys_clk);
      chk_bit(nrfdOe, m != 2, "hold-off start");
      repeat (6) @(posedge sys_clk);
      chk_bit(nrfdOe, m == 4, "matrix ready hold");
      relaySettledPin <= 1'b1;
      settle();
    end
    $display("hold-off done");
    sie_ctl_model_i.send(2'h2, 7'h02);
    pa = $random(seed);
    pb = $random(seed);
    wr_sel_data(7'h63, pa);
    wr_sel_data(7'h32, pb);
    bus(1'b1, `SIE_REG_IRQ_MASK, 32'h0000_0001);
    sie_ctl_model_i.send(2'h0, 7'h32);
    repeat (3) @(posedge sys_clk);
    chk_bit(displayBlank, 1'b1, "panel not blanked");
    settle();
    chk_bit(irq, 1'b1, "insert irq");
    rd(`SIE_REG_IRQ_ST, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    chk_bit(irq, 1'b0, "irq after read");
    bus(1'b1, `SIE_REG_SEL, 32'h0000_0064);
    rd(`SIE_REG_DATA, pa);
    bus(1'b1, `SIE_REG_SEL, 32'h0000_0033);
    rd(`SIE_REG_DATA, pb);
    bus(1'b1, `SIE_REG_SEL, 32'h0000_0032);
    rd(`SIE_REG_DATA, 32'h0000_0000);
    $display("insert done");
    sie_ctl_model_i.send(2'h0, 7'h65);
    sie_ctl_model_i.send(2'h1, 7'h03);
    repeat (3) @(posedge sys_clk);
    chk_bit(irq, 1'b0, "masked reject");
    bus(1'b1, `SIE_REG_IRQ_MASK, 32'h0000_0008);
    repeat (2) @(posedge sys_clk);
    chk_bit(irq, 1'b1, "reject irq");
    rd(`SIE_REG_IRQ_ST, 32'h0000_0008);
    rd(`SIE_REG_DATA, 32'h0000_0000);
    $display("reject done");
    for (int k = 0; k < 2; k++)
    begin
      memFault <= 1'b1;
      sie_ctl_model_i.send(2'h1, 7'h00);
      repeat (4) @(posedge sys_clk);
      chk_bit(nrfdOe, 1'b1, "test hold");
      settle();
      memFault <= 1'b0;
      chk_bit(faultLamp, 1'b1, "lamp");
      rd(`SIE_REG_FAULT, 32'h0000_0001);
      bus(1'b1, `SIE_REG_FAULT, 32'h0000_0000);
      if (k == 0)
        sie_ctl_model_i.send(2'h2, 7'h02);
      keyPressPin <= k[0];
      repeat (8) @(posedge sys_clk);
      keyPressPin <= 1'b0;
      chk_bit(faultLamp, 1'b0, "lamp stays on");
    end
    rd(`SIE_REG_IRQ_ST, 32'h0000_0006);
    $display("self-test done");
    bus(1'b1, `SIE_REG_MODE, 32'h0000_0005);
    bus(1'b1, `SIE_REG_MODE, 32'h0000_0006);
    rd(`SIE_REG_MODE, 32'h0000_0005);
    sie_ctl_model_i.clr();
    rd(`SIE_REG_MODE, 32'h0000_0000);
    sie_ctl_model_i.send(2'h2, 7'h03);
    sie_ctl_model_i.send(2'h3, 7'h00);
    rd(`SIE_REG_MODE, 32'h0000_0000);
    $display("defaults done");
    final_report();
  end
  initial
  begin
    #400_000;
    bad("watchdog");
    final_report();
  end
  task automatic wr_sel_data(input logic [6:0] s, input logic [31:0] d);
    bus(1'b1, `SIE_REG_SEL, {25'h0, s});
    bus(1'b1, `SIE_REG_DATA, d);
  endtask
endmodule
